/* src/vector_priming_sequencer.sv */
`timescale 1ns/1ps
module vector_priming_sequencer #(
	parameter int DW = 64
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                vec_at_l3,
	input  wire logic                vec_at_l4,
	input  wire logic                new_param_file,
	input  wire logic                prior_scalar_new_octet,
	input  wire logic                prior_requests_granted,
	input  wire logic                path_ahead_clear,
	input  wire vps_pkg::op_class_t  op_class,
	input  wire logic                rare_result_op,
	input  wire logic                memory_limited,
	input  wire logic                doubleword,
	input  wire vps_pkg::vec_case_t  vec_case,
	input  wire logic [6:0]          div_rate_q,
	input  wire logic [15:0]         vec_length,
	input  wire logic [7:0]          inner_loop_count,
	input  wire logic [7:0]          outer_loop_count,
	input  wire logic [3:0]          scalar_au_time,
	input  wire logic                item_count_vector,
	input  wire logic                scalar_at_l1,
	input  wire logic                scalar_indirect,
	input  wire logic                scalar_reg_conflict,
	input  wire logic                short_path_ok,
	input  wire logic                cm_data_valid,
	input  wire logic [DW-1:0]       cm_data,
	input  wire logic                au_accept,
	output logic                     pf_fetch_req,
	output logic                     load_register_file_op,
	output logic                     prior_scalar_advance,
	output logic                     init_addr_phase,
	output logic                     param_word_send,
	output logic                     cm_operand_req,
	output logic                     au_operand_valid,
	output logic [DW-1:0]            au_operand,
	output logic                     au_result_strobe,
	output logic                     final_store_write,
	output logic                     vector_busy,
	output logic                     scalar_mbu_grant,
	output logic                     hold_l1,
	output logic                     hold_l3
);
	// ==========================================
	// Sequencer state
	typedef enum logic [2:0] {
		S_IDLE, S_PF_FETCH, S_INIT, S_STREAM, S_DRAIN, S_FLUSH
	} seq_state_t;

	seq_state_t  state_r, state_nxt;
	logic [4:0]  phase_r;       // Clocks since phase start
	logic [4:0]  opf_r;         // Clocks since operand fetch start, held at FIRST_OCTET_CLKS
	logic        opf_on_r;
	logic [4:0]  octet_r;
	logic [6:0]  acc_r;         // Quarter-clock rate accumulator
	logic [31:0] elems_left_r;
	logic [4:0]  drain_r;
	logic [1:0]  result_pipe_r;
	logic        au_full_r;
	logic [DW-1:0] recv_r;      // Receiver register
	logic        recv_v_r;

	// ==========================================
	// Rate selection
	wire [7:0] ni_eff = (inner_loop_count == 8'h00) ? 8'h01 : inner_loop_count;
	wire [7:0] no_eff = (outer_loop_count == 8'h00) ? 8'h01 : outer_loop_count;
	wire [31:0] total_elems = 32'(vec_length) * 32'(ni_eff) * 32'(no_eff);
	wire [6:0] div_q = (div_rate_q < vps_pkg::RATE_Q_DIV_MIN) ? vps_pkg::RATE_Q_DIV_MIN :
		(div_rate_q > vps_pkg::RATE_Q_DIV_MAX) ? vps_pkg::RATE_Q_DIV_MAX : div_rate_q;
	wire [6:0] class_q =
		(op_class == vps_pkg::OP_DADD)   ? vps_pkg::RATE_Q_DADD :
		(op_class == vps_pkg::OP_DMUL)   ? vps_pkg::RATE_Q_DMUL :
		(op_class == vps_pkg::OP_SHIFT)  ? vps_pkg::RATE_Q_SHIFT :
		(op_class == vps_pkg::OP_DDOT)   ? vps_pkg::RATE_Q_DDOT :
		(op_class == vps_pkg::OP_DIVIDE) ? div_q : vps_pkg::RATE_Q_ONE;
	wire [6:0] mem_q = !doubleword ? vps_pkg::RATE_Q_ONE :
		(vec_case == vps_pkg::CASE_VVV) ? vps_pkg::RATE_Q_DADD :
		(vec_case == vps_pkg::CASE_ONE_SCALAR) ? vps_pkg::RATE_Q_ONESRC :
		vps_pkg::RATE_Q_ONE;
	wire [6:0] rate_q = memory_limited ? mem_q : class_q;

	// ==========================================
	// Operand buffer between memory and arithmetic unit
	operand_fifo_if #(.WIDTH(DW)) ofi ();
	operand_fifo #(.WIDTH(DW), .DEPTH(8)) u_fifo (
		.clk (clk),
		.rst (rst),
		.f   (ofi)
	);

	wire first_octet_done = opf_on_r && (opf_r >= vps_pkg::FIRST_OCTET_CLKS);
	wire octet_tick = first_octet_done && (octet_r == vps_pkg::OCTET_PERIOD - 5'h01);
	wire acc_due = (acc_r + 7'h04) >= rate_q;
	wire elem_step = (state_r == S_STREAM) && first_octet_done && acc_due
		&& ofi.out_valid && au_accept && (elems_left_r != 32'h0);
	assign ofi.in_valid  = cm_data_valid && opf_on_r;
	assign ofi.in_data   = cm_data;
	// Leftover words of the last vector are dropped while no fetch runs,
	// so the next vector never starts on stale operands
	assign ofi.out_ready = elem_step || !opf_on_r;

	wire pf_needed   = vec_at_l3 && new_param_file && (state_r == S_IDLE);
	wire reuse_start = vec_at_l4 && !new_param_file && (state_r == S_IDLE);

	// ==========================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (pf_needed) state_nxt = S_PF_FETCH;
				else if (reuse_start) state_nxt = S_INIT;
			end
			S_PF_FETCH: begin
				if (phase_r == vps_pkg::PF_FETCH_CLKS - 5'h01) state_nxt = S_INIT;
			end
			S_INIT: begin
				if (phase_r == vps_pkg::INIT_CLKS - 5'h01) state_nxt = S_STREAM;
			end
			S_STREAM: begin
				if (elem_step && elems_left_r == 32'h1) state_nxt = S_DRAIN;
			end
			S_DRAIN: begin
				if (drain_r == 5'h00) state_nxt = S_FLUSH;
			end
			S_FLUSH: state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= S_IDLE;
			phase_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			phase_r <= (state_nxt != state_r) ? 5'h00 : phase_r + 5'h01;
		end
	end

	// Operand fetch starts five clocks into init and runs until the drain state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opf_on_r <= 1'b0;
			opf_r    <= 5'h00;
			octet_r  <= 5'h00;
		end else begin
			if (state_r == S_INIT && phase_r == vps_pkg::OPF_START_CLKS - 5'h01)
				opf_on_r <= 1'b1;
			else if (state_r == S_DRAIN)
				opf_on_r <= 1'b0;
			if (!opf_on_r) opf_r <= 5'h00;
			else if (!first_octet_done) opf_r <= opf_r + 5'h01;
			if (!first_octet_done || octet_tick) octet_r <= 5'h00;
			else octet_r <= octet_r + 5'h01;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_r        <= 7'h00;
			elems_left_r <= 32'h0;
		end else begin
			if (state_r == S_INIT) elems_left_r <= total_elems;
			else if (elem_step) elems_left_r <= elems_left_r - 32'h1;
			if (state_r != S_STREAM) acc_r <= 7'h00;
			else if (elem_step) acc_r <= 7'(acc_r + 7'h04 - rate_q);
			else if (!acc_due) acc_r <= acc_r + 7'h04;
		end
	end

	// Receiver register and fill pipeline
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			recv_r        <= '0;
			recv_v_r      <= 1'b0;
			au_full_r     <= 1'b0;
			result_pipe_r <= 2'b00;
			drain_r       <= 5'h00;
		end else begin
			recv_v_r <= elem_step;
			if (elem_step) recv_r <= ofi.out_data;
			result_pipe_r <= {result_pipe_r[0], recv_v_r};
			if (state_r == S_IDLE) au_full_r <= 1'b0;
			else if (recv_v_r) au_full_r <= 1'b1;
			if (state_r == S_STREAM) drain_r <= {1'b0, scalar_au_time} + vps_pkg::RECV_LAT_CLKS;
			else if (state_r == S_DRAIN && drain_r != 5'h00) drain_r <= drain_r - 5'h01;
		end
	end

	// ==========================================
	// Outputs
	wire init_words = (state_r == S_INIT) && (phase_r >= vps_pkg::ADDR_WORDS)
		&& (phase_r < vps_pkg::ADDR_WORDS + vps_pkg::PARAM_WORDS);
	assign pf_fetch_req          = (state_r == S_PF_FETCH);
	assign load_register_file_op = (state_r == S_PF_FETCH);
	assign prior_scalar_advance  = pf_needed && prior_scalar_new_octet
		&& prior_requests_granted && path_ahead_clear;
	assign init_addr_phase  = (state_r == S_INIT) && (phase_r < vps_pkg::ADDR_WORDS);
	assign param_word_send  = init_words;
	assign cm_operand_req   = opf_on_r && (!first_octet_done ? (opf_r == 5'h00) : octet_tick)
		&& ofi.in_ready;
	assign au_operand_valid = recv_v_r;
	assign au_operand       = recv_r;
	assign au_result_strobe = result_pipe_r[1];
	assign final_store_write = (state_r == S_FLUSH);
	assign vector_busy      = (state_r != S_IDLE);
	assign scalar_mbu_grant = (state_r == S_IDLE) || (state_r == S_FLUSH);
	assign hold_l1 = scalar_at_l1 && (
		(vector_busy && (scalar_indirect || item_count_vector))
		|| (scalar_reg_conflict && !short_path_ok));
	assign hold_l3 = (state_r == S_PF_FETCH) || (state_r == S_INIT
		&& phase_r < vps_pkg::ADDR_WORDS);

	// ==========================================
	// Checks
	property p_pf_len;
		@(posedge clk) disable iff (rst)
		$rose(pf_fetch_req) |-> pf_fetch_req [*8] ##1 !pf_fetch_req;
	endproperty
	a_pf_len: assert property (p_pf_len) else $error("fetch length wrong");

	property p_reuse;
		@(posedge clk) disable iff (rst)
		reuse_start |=> state_r == S_INIT && !pf_fetch_req;
	endproperty
	a_reuse: assert property (p_reuse) else $error("reuse did not skip fetch");

	sequence s_init_start;
		state_r == S_INIT && phase_r == 5'h00;
	endsequence
	property p_init_len;
		@(posedge clk) disable iff (rst)
		s_init_start |-> ##10 state_r == S_STREAM;
	endproperty
	a_init_len: assert property (p_init_len) else $error("init not ten clocks");

	property p_opf_start;
		@(posedge clk) disable iff (rst)
		s_init_start |-> ##5 cm_operand_req || !ofi.in_ready;
	endproperty
	a_opf_start: assert property (p_opf_start) else $error("fetch not at five");

	property p_words;
		@(posedge clk) disable iff (rst)
		s_init_start |-> !param_word_send [*3] ##1 param_word_send [*5] ##1 !param_word_send;
	endproperty
	a_words: assert property (p_words) else $error("word phase wrong");

	property p_recv;
		@(posedge clk) disable iff (rst)
		elem_step |=> au_operand_valid ##2 au_result_strobe;
	endproperty
	a_recv: assert property (p_recv) else $error("receiver latency wrong");

	property p_flush;
		@(posedge clk) disable iff (rst)
		state_r == S_DRAIN && drain_r == 5'h00 |=> final_store_write ##1 !vector_busy;
	endproperty
	a_flush: assert property (p_flush) else $error("no store flush");

	property p_indirect;
		@(posedge clk) disable iff (rst)
		scalar_at_l1 && scalar_indirect && vector_busy |-> hold_l1;
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect not held");

	property p_grant;
		@(posedge clk) disable iff (rst)
		scalar_mbu_grant |-> !(state_r inside {S_STREAM, S_DRAIN, S_INIT});
	endproperty
	a_grant: assert property (p_grant) else $error("early buffer grant");
endmodule : vector_priming_sequencer

/* src/vps_pkg.sv */
package vps_pkg;
	// ==========================================
	// Timing counts in clocks
	localparam logic [4:0] PF_FETCH_CLKS   = 5'h08;
	localparam logic [4:0] INIT_CLKS       = 5'h0A;
	localparam logic [4:0] ADDR_WORDS      = 5'h03;
	localparam logic [4:0] PARAM_WORDS     = 5'h05;
	localparam logic [4:0] OPF_START_CLKS  = 5'h05;
	localparam logic [4:0] FIRST_OCTET_CLKS = 5'h0C;
	localparam logic [4:0] OCTET_PERIOD    = 5'h08;
	localparam logic [4:0] WORDS_LEAD_CLKS = 5'h07;
	localparam logic [4:0] RECV_LAT_CLKS   = 5'h01;
	// Rates in quarter clocks per element
	localparam logic [6:0] RATE_Q_ONE      = 7'h04;
	localparam logic [6:0] RATE_Q_DADD     = 7'h07;
	localparam logic [6:0] RATE_Q_DMUL     = 7'h0C;
	localparam logic [6:0] RATE_Q_SHIFT    = 7'h08;
	localparam logic [6:0] RATE_Q_DDOT     = 7'h10;
	localparam logic [6:0] RATE_Q_ONESRC   = 7'h05;
	localparam logic [6:0] RATE_Q_DIV_MIN  = 7'h20;
	localparam logic [6:0] RATE_Q_DIV_MAX  = 7'h48;

	typedef enum logic [2:0] {
		OP_SIMPLE,
		OP_DADD,
		OP_DMUL,
		OP_SHIFT,
		OP_DDOT,
		OP_DIVIDE
	} op_class_t;

	typedef enum logic [1:0] {
		CASE_VVV,
		CASE_ONE_SCALAR,
		CASE_SCALAR_RESULT
	} vec_case_t;
endpackage : vps_pkg

/* src/operand_fifo_if.sv */
`timescale 1ns/1ps
interface operand_fifo_if #(
	parameter int WIDTH = 64
);
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : operand_fifo_if

/* src/operand_fifo.sv */
`timescale 1ns/1ps
module operand_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	input  wire logic   clk,
	input  wire logic   rst,
	operand_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	wire              push = f.in_valid && f.in_ready;
	wire              pop  = f.out_valid && f.out_ready;

	assign f.in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign f.out_valid = (cnt_r != '0);
	assign f.out_data  = mem_r[rd_r];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			if (pop) rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (push) mem_r[wr_r] <= f.in_data;
	end
endmodule : operand_fifo

/* sim/mem_model.sv */
`timescale 1ns/1ps
module mem_model #(
	parameter int DW = 64
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          req,
	input  wire logic [3:0]    lat,
	output logic               valid,
	output logic [DW-1:0]      data
);
	// ==========================================
	// Octet delivery, eight words per request
	int            wait_c;
	int            left;
	logic [DW-1:0] word_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_c <= 0;
			left <= 0;
			valid <= 1'b0;
			data <= '0;
			word_r <= DW'(16'hA000);
		end else begin
			valid <= 1'b0;
			// Idle bus toggles so stale data never looks valid
			data <= ~data;
			if (req) begin
				wait_c <= int'(lat);
				left <= left + 8;
			end else if (wait_c != 0) begin
				wait_c <= wait_c - 1;
			end else if (left != 0) begin
				valid <= 1'b1;
				data <= word_r;
				word_r <= word_r + 1'b1;
				left <= left - 1;
			end
		end
	end
endmodule : mem_model

/* sim/vector_priming_sequencer_tb_top.sv */
`timescale 1ns/1ps
module vector_priming_sequencer_tb_top;
	// ==========================================
	// Stimulus and observation
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               l3 = 1'b0, l4 = 1'b0, newpf = 1'b0, oct = 1'b0, grt = 1'b0;
	logic               pclr = 1'b0, rare = 1'b0, meml = 1'b0, dbl = 1'b0, item = 1'b0;
	logic               s1 = 1'b0, sind = 1'b0, sconf = 1'b0, sshort = 1'b0, acc = 1'b1;
	vps_pkg::op_class_t cls = vps_pkg::OP_SIMPLE;
	vps_pkg::vec_case_t vcase = vps_pkg::CASE_VVV;
	logic [6:0]         divq = 7'h20;
	logic [15:0]        len = 16'h0005;
	logic [7:0]         inr = 8'h00, outr = 8'h00;
	logic [3:0]         sat = 4'h3, lat = 4'h1;
	logic               mem_valid;
	logic [63:0]        mem_data;
	logic               pf_fetch_req, load_register_file_op, prior_scalar_advance;
	logic               init_addr_phase, param_word_send, cm_operand_req, au_operand_valid;
	logic [63:0]        au_operand;
	logic               au_result_strobe, final_store_write, vector_busy, scalar_mbu_grant;
	logic               hold_l1, hold_l3;
	int                 n_errors = 0, checks = 0, tick = 0, cyc = 0;
	typedef struct {
		int t0, t_pf, n_pf, n_ld, n_h3, t_in, n_in, t_pw, n_pw, t_rq, n_adv;
		int n_mw, n_op, t_op, t_opl, n_rs, t_rs, n_fs, t_fs, bad_g, bad_h;
		logic g_fs;
		logic [63:0] d_mem, d_op;
	} mon_t;
	mon_t m;

	vector_priming_sequencer #(.DW(64)) vector_priming_sequencer_inst (.clk(clk), .rst(rst),
		.vec_at_l3(l3), .vec_at_l4(l4), .new_param_file(newpf), .prior_scalar_new_octet(oct),
		.prior_requests_granted(grt), .path_ahead_clear(pclr), .op_class(cls),
		.rare_result_op(rare), .memory_limited(meml), .doubleword(dbl), .vec_case(vcase),
		.div_rate_q(divq), .vec_length(len), .inner_loop_count(inr), .outer_loop_count(outr),
		.scalar_au_time(sat), .item_count_vector(item), .scalar_at_l1(s1),
		.scalar_indirect(sind), .scalar_reg_conflict(sconf), .short_path_ok(sshort),
		.cm_data_valid(mem_valid), .cm_data(mem_data), .au_accept(acc),
		.pf_fetch_req(pf_fetch_req), .load_register_file_op(load_register_file_op),
		.prior_scalar_advance(prior_scalar_advance), .init_addr_phase(init_addr_phase),
		.param_word_send(param_word_send), .cm_operand_req(cm_operand_req),
		.au_operand_valid(au_operand_valid), .au_operand(au_operand),
		.au_result_strobe(au_result_strobe), .final_store_write(final_store_write),
		.vector_busy(vector_busy), .scalar_mbu_grant(scalar_mbu_grant),
		.hold_l1(hold_l1), .hold_l3(hold_l3));
	mem_model #(.DW(64)) mem_model_inst (.clk(clk), .rst(rst), .req(cm_operand_req),
		.lat(lat), .valid(mem_valid), .data(mem_data));

	always #20 clk = ~clk;

	// ==========================================
	// Per-cycle monitor, sampled mid-cycle
	always @(negedge clk) begin
		cyc++;
		if (l3 | l4) m.t0 = cyc;
		if (pf_fetch_req) begin
			if (m.n_pf == 0) m.t_pf = cyc;
			m.n_pf++;
			if (hold_l3) m.n_h3++;
		end
		if (load_register_file_op) m.n_ld++;
		if (prior_scalar_advance) m.n_adv++;
		if (init_addr_phase) begin
			if (m.n_in == 0) m.t_in = cyc;
			m.n_in++;
		end
		if (param_word_send) begin
			if (m.n_pw == 0) m.t_pw = cyc;
			m.n_pw++;
		end
		if (cm_operand_req && m.t_rq == 0) m.t_rq = cyc;
		// Words still arriving from the last vector come before any request
		if (mem_valid && m.t_rq != 0 && m.n_mw++ == 0) m.d_mem = mem_data;
		if (au_operand_valid) begin
			if (m.n_op == 0) m.d_op = au_operand;
			if (m.n_op == 0) m.t_op = cyc;
			m.t_opl = cyc;
			m.n_op++;
		end
		if (au_result_strobe && m.n_rs++ == 0) m.t_rs = cyc;
		if (final_store_write) begin
			m.t_fs = cyc;
			m.g_fs = scalar_mbu_grant;
			m.n_fs++;
		end
		if (vector_busy && m.n_fs == 0 && scalar_mbu_grant) m.bad_g++;
		if (vector_busy && s1 && (sind | item) && !hold_l1) m.bad_h++;
	end

	// ==========================================
	// Shared tasks
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic go(input logic use_new, input logic [6:0] q);
		int k;
		int n;
		m = '{default: 0};
		newpf <= use_new;
		l3 <= use_new;
		l4 <= !use_new;
		@(posedge clk);
		l3 <= 1'b0;
		l4 <= 1'b0;
		for (k = 0; k < 3000 && m.n_fs == 0; k++) @(posedge clk);
		repeat (3) @(posedge clk);
		n = len * (inr == 0 ? 1 : inr) * (outr == 0 ? 1 : outr);
		if (use_new) begin
			chk("fetch len", m.n_pf, 8);
			chk("fetch start", m.t_pf - m.t0, 1);
			chk("file load", m.n_ld, 8);
			chk("level3 hold", m.n_h3, 8);
			chk("init after load", m.t_in - m.t_pf, 8);
		end else begin
			chk("no fetch", m.n_pf + m.n_ld, 0);
			chk("init start", m.t_in - m.t0, 1);
		end
		chk("addr phase", m.n_in, 3);
		chk("words", m.n_pw, 5);
		chk("words start", m.t_pw - m.t_in, 3);
		chk("operand req", m.t_rq - m.t_in, 5);
		chk("elements", m.n_op, n);
		chk("results", m.n_rs, n);
		chk("first result", m.t_rs - m.t_op, 2);
		chk("first data", m.d_op, m.d_mem);
		chk("stores", m.n_fs, 1);
		chk("drained", m.t_fs > m.t_opl + 2, 1);
		chk("grant at store", m.g_fs, 1);
		chk("early grant", m.bad_g, 0);
		chk("scalar held", m.bad_h, 0);
		if (q != 0) chk("span", (m.t_opl - m.t_op) * 4, q * (n - 1));
	endtask : go

	task automatic wrap_up;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	always @(posedge clk) begin
		tick++;
		if (tick == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	// ==========================================
	// Scenarios
	task automatic s_overlap;
		{oct, grt, pclr, s1, sind} <= 5'h1F;
		go(1'b1, 7'h04);
		chk("advance", m.n_adv, 1);
		{pclr, sind, item} <= 3'h1;
		cls <= vps_pkg::OP_DMUL;
		go(1'b1, 7'h0C);
		chk("no advance", m.n_adv, 0);
	endtask : s_overlap

	task automatic s_rates;
		vps_pkg::op_class_t cl[6] = '{vps_pkg::OP_SHIFT, vps_pkg::OP_DADD, vps_pkg::OP_DDOT,
			vps_pkg::OP_DIVIDE, vps_pkg::OP_SIMPLE, vps_pkg::OP_SIMPLE};
		logic [6:0]         q[6] = '{7'h08, 7'h07, 7'h10, 7'h20, 7'h07, 7'h05};
		{item, s1} <= 2'h0;
		for (int i = 0; i < 6; i++) begin
			cls <= cl[i];
			rare <= (cl[i] == vps_pkg::OP_DDOT);
			{meml, dbl} <= {2{i > 3}};
			vcase <= (i == 5) ? vps_pkg::CASE_ONE_SCALAR : vps_pkg::CASE_VVV;
			go(1'b0, q[i]);
		end
		vcase <= vps_pkg::CASE_SCALAR_RESULT;
		go(1'b0, 7'h04);
	endtask : s_rates

	task automatic s_loops;
		{meml, dbl} <= 2'h0;
		cls <= vps_pkg::OP_SIMPLE;
		len <= 16'h0002;
		inr <= 8'h03;
		lat <= 4'h6;
		fork
			go(1'b0, 7'h00);
			begin
				repeat (30) @(posedge clk);
				acc <= 1'b0;
				repeat (6) @(posedge clk);
				acc <= 1'b1;
			end
		join
	endtask : s_loops

	task automatic s_conflict;
		{s1, sconf, sshort} <= 3'h6;
		repeat (2) @(posedge clk);
		chk("conflict hold", hold_l1, 1'b1);
		sshort <= 1'b1;
		repeat (2) @(posedge clk);
		chk("short path", hold_l1, 1'b0);
	endtask : s_conflict

	initial begin
		repeat (6) @(posedge clk);
		chk("reset grant", scalar_mbu_grant, 1'b1);
		chk("reset busy", vector_busy | hold_l1 | hold_l3 | pf_fetch_req, 1'b0);
		rst <= 1'b0;
		@(posedge clk);
		s_overlap();
		s_rates();
		s_loops();
		s_conflict();
		wrap_up();
	end
endmodule : vector_priming_sequencer_tb_top
